// [design/irh_pkg.sv]
package irh_pkg;

   localparam logic [7:0] ADDR_HALF_REF_MARGIN = 8'h1B;
   localparam logic [7:0] ADDR_INPUT_PAIRING   = 8'h24;
   localparam logic [7:0] ADDR_COMMON_PIN      = 8'h27;

   localparam logic [7:0] RST_HALF_REF_MARGIN  = 8'h00;
   localparam logic [7:0] RST_INPUT_PAIRING    = 8'h00;
   localparam logic [7:0] RST_COMMON_PIN       = 8'h00;

   localparam int TRIM_LSB   = 4;
   localparam int TRIM_MSB   = 6;
   localparam int MARGIN_EN  = 0;
   localparam int COMMON_BIT = 0;

   localparam logic [2:0] TRIM_NOMINAL = 3'h0;

   localparam logic [1:0] PAIR_SEPARATE   = 2'h0;
   localparam logic [1:0] PAIR_SINGLE     = 2'h1;
   localparam logic [1:0] PAIR_PSEUDO     = 2'h2;
   localparam logic [1:0] PAIR_SEPARATE_B = 2'h3;

   // Routing mode of one channel pair as seen by the analog multiplexer.
   typedef enum logic [1:0] {
      IRH_ROUTE_SEP_SE = 2'h0,
      IRH_ROUTE_SEP_PD = 2'h1,
      IRH_ROUTE_PAIR_SE = 2'h3,
      IRH_ROUTE_PAIR_PD = 2'h2
   } irh_route_t;

   typedef struct packed {
      logic       margin_en;
      logic [2:0] trim_code;
   } irh_halfref_t;

   typedef struct packed {
      logic       neg_to_common;
      logic       pos_even_neg_odd;
      irh_route_t mode;
   } irh_pair_route_t;

   typedef struct packed {
      irh_halfref_t halfref;
      logic [7:0]   pairing;
      logic         common_sel;
      logic [7:0]   rdata;
   } irh_state_t;

endpackage

// [design/irh_pair_decode.sv]
module irh_pair_decode (
   input  wire logic [1:0]               pair_cfg_i,
   input  wire logic                     common_sel_i,
   output irh_pkg::irh_pair_route_t      route_o
);

   always_comb begin
      route_o = '0;
      unique case (pair_cfg_i)
         irh_pkg::PAIR_SINGLE: begin
            route_o.pos_even_neg_odd = 1'b1;
            route_o.mode             = irh_pkg::IRH_ROUTE_PAIR_SE;
         end
         irh_pkg::PAIR_PSEUDO: begin
            route_o.pos_even_neg_odd = 1'b1;
            route_o.mode             = irh_pkg::IRH_ROUTE_PAIR_PD;
         end
         irh_pkg::PAIR_SEPARATE, irh_pkg::PAIR_SEPARATE_B: begin
            route_o.neg_to_common = 1'b1;
            route_o.mode = common_sel_i ? irh_pkg::IRH_ROUTE_SEP_PD
                                        : irh_pkg::IRH_ROUTE_SEP_SE;
         end
      endcase
   end

endmodule // irh_pair_decode

// [design/irh_regs.sv]
module irh_regs (
   input  wire logic                          CLK_SYS_I,
   input  wire logic                          NRST_I,
   input  wire logic                          CE_I,
   input  wire logic [7:0]                    ADDR_I,
   input  wire logic [7:0]                    WDATA_I,
   input  wire logic                          WR_I,
   input  wire logic                          RD_I,
   output logic      [7:0]                    RDATA_O,
   output logic      [2:0]                    HALF_REF_TRIM_O,
   output logic                               HALF_REF_MARGIN_EN_O,
   output irh_pkg::irh_pair_route_t [3:0]     PAIR_ROUTE_O,
   output logic                               COMMON_SEL_O
);

   irh_pkg::irh_state_t             s_q;
   irh_pkg::irh_state_t             s_d;
   irh_pkg::irh_pair_route_t [3:0]  route_d;
   irh_pkg::irh_pair_route_t [3:0]  route_q;

   localparam logic [7:0] RST_HALF = irh_pkg::RST_HALF_REF_MARGIN;

   function automatic logic [7:0] read_mux(input logic [7:0] a,
                                           input irh_pkg::irh_state_t s);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         irh_pkg::ADDR_HALF_REF_MARGIN: begin
            v[irh_pkg::TRIM_MSB:irh_pkg::TRIM_LSB] = s.halfref.trim_code;
            v[irh_pkg::MARGIN_EN]                  = s.halfref.margin_en;
         end
         irh_pkg::ADDR_INPUT_PAIRING: v = s.pairing;
         irh_pkg::ADDR_COMMON_PIN:    v[irh_pkg::COMMON_BIT] = s.common_sel;
         default:                     v = 8'h00;
      endcase
      // Bits 7 and 3..1 of the margin register stay zero by construction.
      return v;
   endfunction

   always_comb begin
      s_d = s_q;
      if (WR_I) begin
         unique case (ADDR_I)
            irh_pkg::ADDR_HALF_REF_MARGIN: begin
               s_d.halfref.trim_code = WDATA_I[irh_pkg::TRIM_MSB:irh_pkg::TRIM_LSB];
               s_d.halfref.margin_en = WDATA_I[irh_pkg::MARGIN_EN];
            end
            irh_pkg::ADDR_INPUT_PAIRING: s_d.pairing = WDATA_I;
            irh_pkg::ADDR_COMMON_PIN:    s_d.common_sel = WDATA_I[irh_pkg::COMMON_BIT];
            default:                     s_d = s_q;
         endcase
      end
      s_d.rdata = RD_I ? read_mux(ADDR_I, s_q) : 8'h00;
   end

   // Channel pair k lives in bits 7-2k..6-2k, so pair 0/1 is the top field.
   genvar k;
   for (k = 0; k < 4; k++) begin : g_pair
      irh_pair_decode u_dec (
         .pair_cfg_i   (s_d.pairing[7-2*k -: 2]),
         .common_sel_i (s_d.common_sel),
         .route_o      (route_d[k])
      );
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         s_q.halfref   <= irh_pkg::irh_halfref_t'({RST_HALF[0], RST_HALF[6:4]});
         s_q.pairing   <= irh_pkg::RST_INPUT_PAIRING;
         s_q.common_sel <= irh_pkg::RST_COMMON_PIN[0];
         s_q.rdata     <= 8'h00;
         // Separate single-ended with the negative output on the common pin.
         route_q       <= {4{irh_pkg::irh_pair_route_t'(4'h8)}};
      end else if (CE_I) begin
         s_q     <= s_d;
         route_q <= route_d;
      end
   end

   logic [2:0] trim_out_q;
   logic       en_out_q;
   logic       com_out_q;

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         trim_out_q <= irh_pkg::TRIM_NOMINAL;
         en_out_q   <= 1'b0;
         com_out_q  <= 1'b0;
      end else if (CE_I) begin
         // Holding the buffer at its nominal code while disabled keeps a stale
         // trim from leaking into the mid-scale output.
         trim_out_q <= s_d.halfref.margin_en ? s_d.halfref.trim_code
                                             : irh_pkg::TRIM_NOMINAL;
         en_out_q   <= s_d.halfref.margin_en;
         com_out_q  <= s_d.common_sel;
      end
   end

   assign RDATA_O              = s_q.rdata;
   assign HALF_REF_TRIM_O      = trim_out_q;
   assign HALF_REF_MARGIN_EN_O = en_out_q;
   assign PAIR_ROUTE_O         = route_q;
   assign COMMON_SEL_O         = com_out_q;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);

   margin_rsvd_zero_a: assert property ((CE_I && RD_I && ADDR_I == irh_pkg::ADDR_HALF_REF_MARGIN)
      |=> (RDATA_O & 8'h8E) == 8'h00) else $error("Reserved margin bits read nonzero.");
   trim_readback_a: assert property ((CE_I && WR_I && ADDR_I == irh_pkg::ADDR_HALF_REF_MARGIN)
      ##1 (CE_I && RD_I && ADDR_I == irh_pkg::ADDR_HALF_REF_MARGIN && !WR_I)
      |=> RDATA_O[6:4] == $past(WDATA_I[6:4], 2)) else $error("Trim code readback wrong.");
   rsvd_low_zero_a: assert property (RDATA_O[3:1] == 3'h0 || $past(ADDR_I) != irh_pkg::ADDR_HALF_REF_MARGIN)
      else $error("Margin bits 3..1 read nonzero.");
   enable_follow_a: assert property ((CE_I && WR_I && ADDR_I == irh_pkg::ADDR_HALF_REF_MARGIN)
      |=> HALF_REF_MARGIN_EN_O == $past(WDATA_I[0])) else $error("Margin enable did not follow.");
   trim_gate_a: assert property (!HALF_REF_MARGIN_EN_O |-> HALF_REF_TRIM_O == irh_pkg::TRIM_NOMINAL)
      else $error("Trim driven while margining off.");
   pairing_write_a: assert property ((CE_I && WR_I && ADDR_I == irh_pkg::ADDR_INPUT_PAIRING)
      |=> PAIR_ROUTE_O[0].pos_even_neg_odd == ($past(WDATA_I[7:6]) inside {2'h1, 2'h2}))
      else $error("Pair 0/1 routing mismatch.");
   sep_common_a: assert property (PAIR_ROUTE_O[3].neg_to_common != PAIR_ROUTE_O[3].pos_even_neg_odd)
      else $error("Separate and paired routing overlap.");
   common_mode_a: assert property (PAIR_ROUTE_O[1].neg_to_common |->
      (PAIR_ROUTE_O[1].mode == irh_pkg::IRH_ROUTE_SEP_PD) == COMMON_SEL_O)
      else $error("Common select not applied.");

   margin_write_c: cover property (CE_I && WR_I && ADDR_I == irh_pkg::ADDR_HALF_REF_MARGIN);
   pair_pd_c:      cover property (PAIR_ROUTE_O[2].mode == irh_pkg::IRH_ROUTE_PAIR_PD);
   common_pd_c:    cover property (COMMON_SEL_O && PAIR_ROUTE_O[0].neg_to_common);

endmodule // irh_regs

// [bench/irh_testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                           CLK_SYS_I = 1'b0;
   logic                           NRST_I    = 1'b0;
   logic                           CE_I      = 1'b1;
   logic                           WR_I      = 1'b0;
   logic                           RD_I      = 1'b0;
   logic [7:0]                     ADDR_I    = 8'h00;
   logic [7:0]                     WDATA_I   = 8'h00;
   logic [7:0]                     RDATA_O;
   logic [2:0]                     HALF_REF_TRIM_O;
   logic                           HALF_REF_MARGIN_EN_O;
   logic                           COMMON_SEL_O;
   irh_pkg::irh_pair_route_t [3:0] PAIR_ROUTE_O;
   logic [7:0]                     m_mrg = 8'h00;
   logic [7:0]                     m_pair = 8'h00;
   logic                           m_com = 1'b0;
   int                             fails = 0;
   int                             checks_done = 0;

   always #2 CLK_SYS_I = ~CLK_SYS_I;

   irh_regs dut_u (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .HALF_REF_TRIM_O(HALF_REF_TRIM_O), .HALF_REF_MARGIN_EN_O(HALF_REF_MARGIN_EN_O),
      .PAIR_ROUTE_O(PAIR_ROUTE_O), .COMMON_SEL_O(COMMON_SEL_O));

   function automatic logic [7:0] rd_exp(logic [7:0] a);
      case (a)
         irh_pkg::ADDR_HALF_REF_MARGIN: return m_mrg;
         irh_pkg::ADDR_INPUT_PAIRING:   return m_pair;
         irh_pkg::ADDR_COMMON_PIN:      return {7'h00, m_com};
         default:                       return 8'h00;
      endcase
   endfunction

   function automatic logic [3:0] route(logic [1:0] c);
      case (c)
         2'h1:    return 4'h7;
         2'h2:    return 4'h6;
         default: return {3'h4, m_com};
      endcase
   endfunction

   task automatic chk_rd(logic [7:0] e);
      checks_done++;
      if (RDATA_O !== e) begin
         fails++;
         $display("unexpected RDATA_O exp %h got %h", e, RDATA_O);
      end
   endtask

   task automatic chk_cfg;
      logic [20:0] e;
      logic [20:0] g;
      e = {m_mrg[0] ? m_mrg[6:4] : 3'h0, m_mrg[0], m_com, route(m_pair[1:0]),
           route(m_pair[3:2]), route(m_pair[5:4]), route(m_pair[7:6])};
      g = {HALF_REF_TRIM_O, HALF_REF_MARGIN_EN_O, COMMON_SEL_O, PAIR_ROUTE_O};
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("unexpected config outputs exp %h got %h", e, g);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      ADDR_I  <= a;
      WDATA_I <= d;
      WR_I    <= 1'b1;
      @(posedge CLK_SYS_I);
      WR_I <= 1'b0;
      if (CE_I === 1'b1) begin
         if (a == 8'h1B) m_mrg = d & 8'h71;
         if (a == 8'h24) m_pair = d;
         if (a == 8'h27) m_com = d[0];
      end
      @(negedge CLK_SYS_I);
      chk_cfg();
      @(posedge CLK_SYS_I);
   endtask

   // The read data must be cleared again one cycle later, so both cycles are compared.
   task automatic rd(logic [7:0] a);
      ADDR_I <= a;
      RD_I   <= 1'b1;
      @(posedge CLK_SYS_I);
      RD_I <= 1'b0;
      @(negedge CLK_SYS_I);
      chk_rd(rd_exp(a));
      @(negedge CLK_SYS_I);
      chk_rd(8'h00);
      @(posedge CLK_SYS_I);
   endtask

   task automatic close_out;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      fails++;
      close_out();
   end

   initial begin
      logic [7:0] adr [6] = '{8'h1B, 8'h24, 8'h27, 8'h00, 8'h1A, 8'hFF};
      int         seed;
      seed = $urandom(60980);
      repeat (3) @(posedge CLK_SYS_I);
      NRST_I <= 1'b1;
      @(posedge CLK_SYS_I);
      chk_cfg();
      for (int i = 0; i < 6; i++) rd(adr[i]);
      wr(8'h1B, 8'h71);
      rd(8'h1B);
      wr(8'h1B, 8'h70);
      wr(8'h24, 8'h1B);
      wr(8'h27, 8'hFF);
      wr(8'h24, 8'hE4);
      rd(8'h27);
      // With the clock enable low nothing may change.
      CE_I <= 1'b0;
      wr(8'h24, 8'h55);
      CE_I <= 1'b1;
      rd(8'h24);
      repeat (60) begin
         int k;
         k = $urandom_range(5);
         wr(adr[k], (adr[k] == 8'h1B) ? (8'($urandom) & 8'h71) : 8'($urandom));
         rd(adr[k]);
      end
      close_out();
   end
endmodule // testbench
